// File: rtl/ofc_pkg.sv
// ofc_pkg: constants, types and the register map for the operand fork and cc store.
// assumes a single 125 MHz clock and an AXI4-Lite master reaching the registers.
// Operation
// - decode 3-bit source and destination mode fields into one-hot signals
// - destination fork gives 202-211 for mode zero, 110-117 otherwise
// - destination fork bits 4,5 zero; top two bits follow mode-zero decode
// - destination bit 3 set for nonzero modes, or floating class in mode zero
// - mode zero: pc gives 202/203, else 204/205, lower when odd-byte; float 211
// - nonzero modes: 110/111, 112/113, 114/115, 116/117, even when odd-byte set
// - mode-zero decode steers destination mux between its two input sets
// - plain exec class goes to 031 except negate and odd-byte right shifts
// - test/compare 033, subroutine call 034, jump 035, floating class 036
// - product 060, divide 061, shift 062, combined 063, odd right 064, mfp 066
// - negate disables execute mux, all ones, giving 067
// - second set forces bit 4 one; first set bit 4 one and bit 3 asserted
// - flags n z v c held in four low bits of status word
// - flags change only on explicit data operations, not address calculations
// - flags clocked only on data-op cycles, except when load select equals 2
// - unchanged flags reload their own value through generation logic
// - low status byte address forces flags directly from bus data buffer
// - operate op: ir bit 4 picks set or clear; only bits with ones change
// - ir set or clear suppresses the normal clocked flag load
// - bus data buffer load wins over a simultaneous clocked load
// - z held in two flops ored, both loaded together on direct loads
// - load select 0 leaves flags, 1 makes update instruction dependent
package ofc_pkg;
  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [3:0] REG_INSTR = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_FORK = 4'h8;
  localparam logic [3:0] REG_FLAGS = 4'hC;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ctrl register fields
  localparam int CTRL_LOAD_LSB = 0;   // cc_load_select, 3 bits
  localparam int CTRL_ODD = 3;        // odd_byte_select
  localparam int CTRL_PSLOW = 4;      // bus address hits low status byte
  localparam int CTRL_FLOAT = 5;      // floating class instruction
  localparam int CTRL_DATAOP = 6;     // cycle operates on data
  localparam int CTRL_DR0 = 7;        // odd byte for byte right shift
  localparam int CTRL_BUF_LSB = 8;    // bus_data_buffer low nibble
  localparam int CTRL_GEN_LSB = 12;   // generated n z v c data
  localparam int CTRL_GEN_EN_LSB = 16; // per-flag update enables
  localparam logic [2:0] CCL_NONE = 3'h0;
  localparam logic [2:0] CCL_INSDEP = 3'h1;
  localparam logic [2:0] CCL_INHIBIT = 3'h2;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  // ************************************************************
  // microprogram fork addresses (octal in comments)
  // ************************************************************
  localparam logic [7:0] DF_PC_ODD = 8'h82;     // 202
  localparam logic [7:0] DF_PC_EVEN = 8'h83;    // 203
  localparam logic [7:0] DF_REG_ODD = 8'h84;    // 204
  localparam logic [7:0] DF_REG_EVEN = 8'h85;   // 205
  localparam logic [7:0] DF_FLOAT = 8'h89;      // 211
  localparam logic [7:0] DF_M12_ODD = 8'h48;    // 110
  localparam logic [7:0] DF_M3_ODD = 8'h4A;     // 112
  localparam logic [7:0] DF_M45_ODD = 8'h4C;    // 114
  localparam logic [7:0] DF_M67_ODD = 8'h4E;    // 116
  localparam logic [7:0] EF_EXEC = 8'h19;       // 031
  localparam logic [7:0] EF_TEST = 8'h1B;       // 033
  localparam logic [7:0] EF_CALL = 8'h1C;       // 034
  localparam logic [7:0] EF_JUMP = 8'h1D;       // 035
  localparam logic [7:0] EF_FLOAT = 8'h1E;      // 036
  localparam logic [7:0] EF_PRODUCT = 8'h30;    // 060
  localparam logic [7:0] EF_DIVIDE = 8'h31;     // 061
  localparam logic [7:0] EF_SHIFT = 8'h32;      // 062
  localparam logic [7:0] EF_SHIFTC = 8'h33;     // 063
  localparam logic [7:0] EF_ODDRIGHT = 8'h34;   // 064
  localparam logic [7:0] EF_MFP = 8'h36;        // 066
  localparam logic [7:0] EF_NEGATE = 8'h37;     // 067
  // instruction opcodes matched on the upper bits
  localparam logic [9:0] OP_NEG = 10'h02C;      // 0054
  localparam logic [9:0] OP_NEGB = 10'h22C;     // 1054
  localparam logic [9:0] OP_TST = 10'h02F;      // 0057
  localparam logic [9:0] OP_TSTB = 10'h22F;     // 1057
  localparam logic [9:0] OP_BYTE_ARITH_RIGHT_OP = 10'h232;     // 1062
  localparam logic [9:0] OP_BYTE_ROTATE_RIGHT_OP = 10'h230;     // 1060
  localparam logic [9:0] OP_JMP = 10'h001;      // 0001
  localparam logic [9:0] OP_MFP = 10'h035;      // 0065
  localparam logic [6:0] OP_JSR = 7'h04;        // 004R
  localparam logic [6:0] OP_MUL = 7'h38;        // 070R
  localparam logic [6:0] OP_DIV = 7'h39;        // 071R
  localparam logic [6:0] OP_ASH = 7'h3A;        // 072R
  localparam logic [6:0] OP_ARITH_SHIFT_COMBINED_OP = 7'h3B;       // 073R
  localparam logic [9:0] OP_CC_OPERATE_OP_HI = 10'h002;  // 0002xx
  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic [7:0] src_mode;
    logic [7:0] dst_mode;
  } ofc_modes_s;
  typedef struct packed {
    logic n;
    logic z1;
    logic z2;
    logic v;
    logic c;
  } ofc_flags_s;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRESP = 2'b01,
    BUS_RDATA = 2'b10
  } ofc_bus_e;
endpackage

// File: rtl/ofc_top.sv
// ofc_top: operand fork decode and condition-code store behind an AXI4-Lite slave.
// assumes one clock, synchronous active-high reset, master holds payload until taken.
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ofc_top (
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic [7:0] dest_fork_q,
  output logic [7:0] exec_fork_q,
  output logic [3:0] proc_status_word_q
);
  // ************************************************************
  // software-visible state
  // ************************************************************
  logic [15:0] instr_reg_q;
  logic [19:0] ctrl_q;
  logic ctrl_wr;
  ofc_pkg::ofc_flags_s flags_q;
  ofc_pkg::ofc_modes_s modes;
  logic [7:0] dest_fork_d;
  logic [7:0] exec_fork_d;
  logic [2:0] cc_load_select;
  logic odd_byte_select;
  logic [3:0] bus_data_buffer;
  logic dest_is_pc;
  logic dest_mode_is_zero;
  logic dest_mode_one_two;
  logic dest_mode_three;
  logic dest_mode_four_five;
  logic dest_mode_six_seven;
  logic is_float;
  logic twos_complement_op;
  logic byte_arith_right_op;
  logic byte_rotate_right_op;
  logic product_op;
  logic divide_op;
  logic arith_shift_op;
  logic arith_shift_combined_op;
  logic move_from_prev_space;
  logic subroutine_call_op;
  logic jump_op;
  logic test_op;
  logic compare_op;
  logic odd_right;
  logic cc_operate_op;

  assign cc_load_select = ctrl_q[ofc_pkg::CTRL_LOAD_LSB +: 3];
  assign odd_byte_select = ctrl_q[ofc_pkg::CTRL_ODD];
  assign bus_data_buffer = ctrl_q[ofc_pkg::CTRL_BUF_LSB +: 4];
  assign is_float = ctrl_q[ofc_pkg::CTRL_FLOAT];

  // ************************************************************
  // mode decode
  // ************************************************************
  // one-hot mode decode
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_mode
      assign modes.src_mode[gi] = (instr_reg_q[11:9] == 3'(gi));
      assign modes.dst_mode[gi] = (instr_reg_q[5:3] == 3'(gi));
    end
  endgenerate
  assign dest_mode_is_zero = modes.dst_mode[0];
  assign dest_mode_one_two = modes.dst_mode[1] | modes.dst_mode[2];
  assign dest_mode_three = modes.dst_mode[3];
  assign dest_mode_four_five = modes.dst_mode[4] | modes.dst_mode[5];
  assign dest_mode_six_seven = modes.dst_mode[6] | modes.dst_mode[7];
  assign dest_is_pc = (instr_reg_q[2:0] == 3'h7);

  // opcode group decode
  assign twos_complement_op = (instr_reg_q[15:6] == ofc_pkg::OP_NEG) |
                              (instr_reg_q[15:6] == ofc_pkg::OP_NEGB);
  assign byte_arith_right_op = (instr_reg_q[15:6] == ofc_pkg::OP_BYTE_ARITH_RIGHT_OP);
  assign byte_rotate_right_op = (instr_reg_q[15:6] == ofc_pkg::OP_BYTE_ROTATE_RIGHT_OP);
  assign product_op = (instr_reg_q[15:9] == ofc_pkg::OP_MUL);
  assign divide_op = (instr_reg_q[15:9] == ofc_pkg::OP_DIV);
  assign arith_shift_op = (instr_reg_q[15:9] == ofc_pkg::OP_ASH);
  assign arith_shift_combined_op = (instr_reg_q[15:9] == ofc_pkg::OP_ARITH_SHIFT_COMBINED_OP);
  assign move_from_prev_space = (instr_reg_q[15:6] == ofc_pkg::OP_MFP);
  assign subroutine_call_op = (instr_reg_q[15:9] == ofc_pkg::OP_JSR);
  assign jump_op = (instr_reg_q[15:6] == ofc_pkg::OP_JMP);
  assign test_op = (instr_reg_q[15:6] == ofc_pkg::OP_TST) |
                   (instr_reg_q[15:6] == ofc_pkg::OP_TSTB);
  // compare and mask-test word or byte: opcode x2 and x3 in bits 14:12
  assign compare_op = (instr_reg_q[14:12] == 3'h2) | (instr_reg_q[14:12] == 3'h3);
  assign odd_right = (byte_arith_right_op | byte_rotate_right_op) & ctrl_q[ofc_pkg::CTRL_DR0];
  assign cc_operate_op = (instr_reg_q[15:6] == ofc_pkg::OP_CC_OPERATE_OP_HI) &
                         (instr_reg_q[5] == 1'b1);

  // ************************************************************
  // destination fork
  // ************************************************************
  // combinational from instruction and status, registered only at the port
  always_comb begin
    dest_fork_d = 8'h00;
    if (dest_mode_is_zero) begin
      if (is_float) begin
        dest_fork_d = ofc_pkg::DF_FLOAT;
      end else if (dest_is_pc) begin
        dest_fork_d = odd_byte_select ? ofc_pkg::DF_PC_ODD : ofc_pkg::DF_PC_EVEN;
      end else begin
        dest_fork_d = odd_byte_select ? ofc_pkg::DF_REG_ODD : ofc_pkg::DF_REG_EVEN;
      end
    end else begin
      // nonzero mode targets, even when odd-byte
      if (dest_mode_one_two) begin
        dest_fork_d = ofc_pkg::DF_M12_ODD;
      end else if (dest_mode_three) begin
        dest_fork_d = ofc_pkg::DF_M3_ODD;
      end else if (dest_mode_four_five) begin
        dest_fork_d = ofc_pkg::DF_M45_ODD;
      end else if (dest_mode_six_seven) begin
        dest_fork_d = ofc_pkg::DF_M67_ODD;
      end
      dest_fork_d[0] = ~odd_byte_select;
    end
    // bits 4,5 zero, top bits from decode
    dest_fork_d[5:4] = 2'b00;
    dest_fork_d[7] = dest_mode_is_zero;
    dest_fork_d[6] = ~dest_mode_is_zero;
    dest_fork_d[3] = ~dest_mode_is_zero | is_float;
    // range 202-211 or 110-117 follows from the above
  end

  // ************************************************************
  // execute fork
  // ************************************************************
  always_comb begin
    exec_fork_d = ofc_pkg::EF_EXEC;
    if (twos_complement_op) begin
      exec_fork_d = ofc_pkg::EF_NEGATE;
    end else if (product_op) begin
      exec_fork_d = ofc_pkg::EF_PRODUCT;
    end else if (divide_op) begin
      exec_fork_d = ofc_pkg::EF_DIVIDE;
    end else if (arith_shift_op) begin
      exec_fork_d = ofc_pkg::EF_SHIFT;
    end else if (arith_shift_combined_op) begin
      exec_fork_d = ofc_pkg::EF_SHIFTC;
    end else if (odd_right) begin
      exec_fork_d = ofc_pkg::EF_ODDRIGHT;
    end else if (move_from_prev_space) begin
      exec_fork_d = ofc_pkg::EF_MFP;
    end else if (is_float) begin
      exec_fork_d = ofc_pkg::EF_FLOAT;
    end else if (subroutine_call_op) begin
      exec_fork_d = ofc_pkg::EF_CALL;
    end else if (jump_op) begin
      exec_fork_d = ofc_pkg::EF_JUMP;
    end else if (test_op | compare_op) begin
      exec_fork_d = ofc_pkg::EF_TEST;
    end else begin
      exec_fork_d = ofc_pkg::EF_EXEC;
    end
    // bit 4 and bit 3 by input set
    if (!twos_complement_op) begin
      exec_fork_d[4] = (exec_fork_d[5:4] == 2'b11);
      exec_fork_d[3] = (exec_fork_d[5:4] != 2'b11);
      exec_fork_d[4] = exec_fork_d[4] | exec_fork_d[3];
    end
  end

  // fork ports are flopped so the outputs come straight from flip-flops
  always_ff @(posedge clk) begin
    if (srst) begin
      dest_fork_q <= 8'h00;
      exec_fork_q <= 8'h00;
    end else begin
      dest_fork_q <= dest_fork_d;
      exec_fork_q <= exec_fork_d;
    end
  end

  // ************************************************************
  // condition-code store
  // ************************************************************
  logic [3:0] gen_data;
  logic [3:0] gen_en;
  logic clocked_load;
  logic ir_load;
  logic [3:0] ir_mask;
  logic [3:0] load_val;
  assign gen_data = ctrl_q[ofc_pkg::CTRL_GEN_LSB +: 4];
  assign gen_en = ctrl_q[ofc_pkg::CTRL_GEN_EN_LSB +: 4];
  assign ir_mask = instr_reg_q[3:0];
  // operate op only when load select asks ir set/clear
  assign ir_load = cc_operate_op & (cc_load_select == ofc_pkg::CCL_INHIBIT);
  // clock inhibited by select 2 or ir load; data ops only
  assign clocked_load = (cc_load_select != ofc_pkg::CCL_INHIBIT) & ~ir_load &
                        ctrl_q[ofc_pkg::CTRL_DATAOP];

  always_comb begin
    load_val = {flags_q.n, flags_q.z1 | flags_q.z2, flags_q.v, flags_q.c};
    if (cc_load_select == ofc_pkg::CCL_INSDEP) begin
      load_val = (gen_data & gen_en) | (load_val & ~gen_en);
    end else if (cc_load_select != ofc_pkg::CCL_NONE) begin
      load_val = gen_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      flags_q <= '0;
    // bus buffer load wins, both z flops together
    end else if (ctrl_q[ofc_pkg::CTRL_PSLOW]) begin
      flags_q <= {bus_data_buffer[3], bus_data_buffer[2], bus_data_buffer[2],
                  bus_data_buffer[1], bus_data_buffer[0]};
    end else if (ir_load) begin
      if (instr_reg_q[4]) begin
        flags_q.n <= flags_q.n | ir_mask[3];
        flags_q.z1 <= ir_mask[2] ? 1'b1 : flags_q.z1;
        flags_q.z2 <= ir_mask[2] ? 1'b1 : flags_q.z2;
        flags_q.v <= flags_q.v | ir_mask[1];
        flags_q.c <= flags_q.c | ir_mask[0];
      end else begin
        flags_q.n <= flags_q.n & ~ir_mask[3];
        flags_q.z1 <= flags_q.z1 & ~ir_mask[2];
        flags_q.z2 <= flags_q.z2 & ~ir_mask[2];
        flags_q.v <= flags_q.v & ~ir_mask[1];
        flags_q.c <= flags_q.c & ~ir_mask[0];
      end
    end else if (clocked_load) begin
      // second z flop gets the same data; split only saves an or stage
      flags_q <= {load_val[3], load_val[2], load_val[2], load_val[1], load_val[0]};
    end
  end

  // flags in low four status bits
  always_ff @(posedge clk) begin
    if (srst) begin
      proc_status_word_q <= ofc_pkg::FLAGS_RST;
    end else begin
      proc_status_word_q <= {flags_q.n, flags_q.z1 | flags_q.z2, flags_q.v, flags_q.c};
    end
  end

  // ************************************************************
  // axi4-lite slave
  // ************************************************************
  ofc_pkg::ofc_bus_e wst_q;
  logic aw_got_q;
  logic w_got_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [31:0] rd_mux;
  logic [31:0] wmask;
  logic wr_hit;

  // address and data may arrive in either order; each is held until both are in
  always_ff @(posedge clk) begin
    if (srst) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp <= ofc_pkg::RESP_OKAY;
      wst_q <= ofc_pkg::BUS_IDLE;
    end else begin
      case (wst_q)
        ofc_pkg::BUS_IDLE: begin
          if (s_awvalid && s_awready) begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_awaddr;
          end
          if (s_wvalid && s_wready) begin
            w_got_q <= 1'b1;
            wdata_q <= s_wdata;
            wstrb_q <= s_wstrb;
          end
          if (aw_got_q && w_got_q) begin
            s_bvalid <= 1'b1;
            s_bresp <= wr_hit ? ofc_pkg::RESP_OKAY : ofc_pkg::RESP_SLVERR;
            wst_q <= ofc_pkg::BUS_WRESP;
          end
        end
        ofc_pkg::BUS_WRESP: begin
          if (s_bready) begin
            s_bvalid <= 1'b0;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            wst_q <= ofc_pkg::BUS_IDLE;
          end
        end
        default: begin
          wst_q <= ofc_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // ready is a register so the slave never looks at valid combinationally
  always_ff @(posedge clk) begin
    if (srst) begin
      s_awready <= 1'b0;
      s_wready <= 1'b0;
    end else begin
      s_awready <= (wst_q == ofc_pkg::BUS_IDLE) & ~aw_got_q & ~(s_awvalid & s_awready);
      s_wready <= (wst_q == ofc_pkg::BUS_IDLE) & ~w_got_q & ~(s_wvalid & s_wready);
    end
  end

  assign wr_hit = (awaddr_q == ofc_pkg::REG_INSTR) | (awaddr_q == ofc_pkg::REG_CTRL);
  assign ctrl_wr = (wst_q == ofc_pkg::BUS_IDLE) & aw_got_q & w_got_q;
  always_comb begin
    wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  end

  // register writes apply in the cycle bvalid rises
  always_ff @(posedge clk) begin
    if (srst) begin
      instr_reg_q <= 16'h0000;
      ctrl_q <= 20'h00000;
    end else if (ctrl_wr) begin
      if (awaddr_q == ofc_pkg::REG_INSTR) begin
        instr_reg_q <= (wdata_q[15:0] & wmask[15:0]) | (instr_reg_q & ~wmask[15:0]);
      end
      if (awaddr_q == ofc_pkg::REG_CTRL) begin
        ctrl_q <= (wdata_q[19:0] & wmask[19:0]) | (ctrl_q & ~wmask[19:0]);
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    case (s_araddr)
      ofc_pkg::REG_INSTR: rd_mux = {16'h0000, instr_reg_q};
      ofc_pkg::REG_CTRL: rd_mux = {12'h000, ctrl_q};
      ofc_pkg::REG_FORK: rd_mux = {16'h0000, exec_fork_q, dest_fork_q};
      ofc_pkg::REG_FLAGS: rd_mux = {27'h0, flags_q};
      default: rd_mux = 32'h0;
    endcase
  end

  // one read at a time; arready drops while rvalid waits
  always_ff @(posedge clk) begin
    if (srst) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0;
      s_rresp <= ofc_pkg::RESP_OKAY;
    end else if (s_rvalid) begin
      if (s_rready) begin
        s_rvalid <= 1'b0;
      end
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rdata <= rd_mux;
      s_rresp <= (s_araddr[1:0] == 2'b00) ? ofc_pkg::RESP_OKAY : ofc_pkg::RESP_SLVERR;
    end else begin
      s_arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: verif/ofc_seq_model.sv
// ofc_seq_model: microprogram sequencer stand-in latching one fork address.
// assumes forks settle within a cycle; sel picks which fork is taken.
`timescale 1ns/1ps
`default_nettype none
module ofc_seq_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic sel,
  input wire logic [7:0] dest_fork,
  input wire logic [7:0] exec_fork,
  output logic [7:0] upc_q
);
  // next address latched every cycle, as the sequencer does
  always_ff @(posedge clk) begin
    if (srst) begin
      upc_q <= 8'h00;
    end else begin
      upc_q <= sel ? exec_fork : dest_fork;
    end
  end
endmodule
`default_nettype wire

// File: verif/ofc_top_bench.sv
// ofc_top_bench: drives ofc_top over AXI4-Lite and checks forks and flags.
// assumes 125 MHz clock; responses are compared in order by a monitor.
`timescale 1ns/1ps
`default_nettype none
module ofc_top_bench;
  logic clk, srst, s_awvalid, s_wvalid, s_arvalid, sel, s_bready, s_rready;
  logic [3:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, v;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp;
  logic [31:0] s_rdata, et[16];
  logic [7:0] dest_fork_q, exec_fork_q, upc_q;
  logic [3:0] proc_status_word_q;
  logic [65:0] q[$];
  logic [65:0] e;
  int fails = 0, checks = 0, cyc = 0, seed = 52;
  ofc_top u_dut (.clk(clk), .srst(srst), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hF), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .dest_fork_q(dest_fork_q),
    .exec_fork_q(exec_fork_q), .proc_status_word_q(proc_status_word_q));
  ofc_seq_model u_seq (.clk(clk), .srst(srst), .sel(sel), .dest_fork(dest_fork_q),
    .exec_fork(exec_fork_q), .upc_q(upc_q));
  // ************************************************************
  // helpers
  // ************************************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic finish_test;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    q.push_back({32'h0, r, 32'h0});
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      ad = ad | (s_awvalid & s_awready);
      wd = wd | (s_wvalid & s_wready);
      s_awvalid <= !ad;
      s_wvalid <= !wd;
    end while (!(ad && wd));
    // answer taken late at random so a stalled response must hold
    repeat ($random(seed) & 3) @(posedge clk);
    s_bready <= 1'b1;
    do @(posedge clk); while (s_bvalid !== 1'b1);
    s_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [33:0] x);
    q.push_back({m, x});
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do @(posedge clk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    repeat ($random(seed) & 3) @(posedge clk);
    s_rready <= 1'b1;
    do @(posedge clk); while (s_rvalid !== 1'b1);
    s_rready <= 1'b0;
  endtask
  function automatic logic [7:0] dexp(logic [2:0] m, logic [2:0] g, logic o, logic f);
    if (m == 3'h0) return f ? 8'h89 : g == 3'h7 ? (o ? 8'h82 : 8'h83) : (o ? 8'h84 : 8'h85);
    return (m < 3'h3 ? 8'h48 : m == 3'h3 ? 8'h4A : m < 3'h6 ? 8'h4C : 8'h4E) + {7'h0, !o};
  endfunction
  // responses are matched in order against the oldest note
  always @(posedge clk) begin
    if ((s_bvalid && s_bready) === 1'b1 || (s_rvalid && s_rready) === 1'b1) begin
      e = q.pop_front();
      chk({30'h0, s_bvalid ? s_bresp : s_rresp}, {30'h0, e[33:32]});
      chk((s_bvalid ? 32'h0 : s_rdata) & e[65:34], e[31:0]);
    end
  end
  // clock and hang guard; a run needs well under 20000 cycles
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      finish_test;
    end
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {srst, s_awvalid, s_wvalid, s_arvalid, sel, s_bready, s_rready} = 7'b1000000;
    {s_awaddr, s_araddr, s_wdata} = '0;
    et = '{32'h0B000037, 32'h0BC0001B, 32'h8BC0001B, 32'h2000001B, 32'h0040001D,
      32'h0800001C, 32'h70000030, 32'h72000031, 32'h74000032, 32'h76000033, 32'h0D400036,
      32'h8C808034, 32'h8C008034, 32'h8C000019, 32'h0A00201E, 32'h0A000019};
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(4'hC, 32'h1F, 34'h0);
    chk({28'h0, proc_status_word_q}, 32'h0);
    wr(4'h4, 32'h0A10, 2'h0);
    rd(4'hC, 32'h1F, 34'h12);
    chk({28'h0, proc_status_word_q}, 32'hA);
    wr(4'h4, 32'h0410, 2'h0);
    rd(4'hC, 32'h1F, 34'h0C);
    wr(4'h4, 32'h2, 2'h0);
    wr(4'h0, 32'h00B5, 2'h0);
    rd(4'hC, 32'h1F, 34'h0D);
    wr(4'h0, 32'h00A4, 2'h0);
    rd(4'hC, 32'h1F, 34'h01);
    wr(4'h4, 32'hF040, 2'h0);
    rd(4'hC, 32'h1F, 34'h01);
    wr(4'h4, 32'h9E041, 2'h0);
    rd(4'hC, 32'h1F, 34'h10);
    wr(4'h4, 32'h3, 2'h0);
    rd(4'hC, 32'h1F, 34'h10);
    wr(4'h0, 32'h0A00, 2'h0);
    wr(4'h4, 32'hF042, 2'h0);
    rd(4'hC, 32'h1F, 34'h10);
    wr(4'h4, 32'hF053, 2'h0);
    rd(4'hC, 32'h1F, 34'h00);
    wr(4'h4, 32'h5043, 2'h0);
    rd(4'hC, 32'h13, 34'h01);
    $display("test flags done");
    sel <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      wr(4'h4, {24'h0, et[i][15:8]}, 2'h0);
      wr(4'h0, {16'h0, et[i][31:16]}, 2'h0);
      rd(4'h8, 32'hFF00, {2'h0, 16'h0, et[i][7:0], 8'h0});
      chk({24'h0, upc_q}, {24'h0, et[i][7:0]});
    end
    $display("test exec fork done");
    sel <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      v = $random(seed);
      wr(4'h0, {16'h0, v[15:0]}, 2'h0);
      wr(4'h4, {26'h0, v[21], 1'b0, v[20], 3'h0}, 2'h0);
      rd(4'h8, 32'hFF, {26'h0, dexp(v[5:3], v[2:0], v[20], v[21])});
      chk({24'h0, upc_q}, {24'h0, dexp(v[5:3], v[2:0], v[20], v[21])});
    end
    $display("test dest fork done");
    wr(4'h8, 32'h0, 2'h2);
    wr(4'hC, 32'h0, 2'h2);
    rd(4'h1, 32'h0, 34'h200000000);
    $display("test bus errors done");
    repeat (5) @(posedge clk);
    finish_test;
  end
endmodule
`default_nettype wire

// File: verif/ofc_top_chk.sv
// ofc_top_chk: bus handshake and fork address properties on the ofc_top ports.
// assumes bound to ofc_top, srst synchronous active high.
`timescale 1ns/1ps
`default_nettype none
module ofc_top_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic [1:0] s_bresp,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic s_rvalid,
  input wire logic s_rready,
  input wire logic [7:0] dest_fork_q,
  input wire logic [7:0] exec_fork_q
);
  // ************************************************************
  // properties
  // ************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence wr_taken;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  sequence rd_taken;
    s_arvalid && s_arready;
  endsequence
  bresp_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("bresp dropped early");
  rdata_hold_a: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("rdata dropped early");
  wr_answer_a: assert property (wr_taken |-> ##[1:3] s_bvalid)
    else $error("no write response");
  rd_answer_a: assert property (rd_taken |-> ##[1:2] s_rvalid)
    else $error("no read data");
  rd_order_a: assert property (s_rvalid |-> !s_arready)
    else $error("second read accepted");
  dfork_fixed_a: assert property (!$past(srst) |-> dest_fork_q[5:4] == 2'b00 &&
    dest_fork_q[7] != dest_fork_q[6]) else $error("dest fork fixed bits wrong");
  dfork_bit_three_a: assert property (dest_fork_q[6] |-> dest_fork_q[3])
    else $error("dest fork bit 3 low");
  efork_second_a: assert property (exec_fork_q[5] |-> exec_fork_q[4])
    else $error("exec fork bit 4 low");
  efork_first_a: assert property (exec_fork_q[4] && !exec_fork_q[5] |-> exec_fork_q[3])
    else $error("exec fork bit 3 low");
endmodule
bind ofc_top ofc_top_chk u_chk (.*);
`default_nettype wire
